// ==== shared/ssf_pkg.sv ====
// Purpose: Shared constants and types for the synchronous serial frame block
// Assumes: One peripheral clock; serial clocks arrive as sampled pins
// Notes:   Field encodings are minus-one where a count starts at one
package ssf_pkg;
    localparam int unsigned WORD_W     = 32;
    localparam int unsigned WLEN_W     = 5;
    localparam int unsigned WNUM_W     = 4;
    localparam int unsigned DLY_W      = 8;
    localparam int unsigned SLEN_W     = 9;
    localparam int unsigned PER_W      = 9;
    localparam int unsigned BCNT_W     = 6;
    localparam int unsigned SYNC_REG_W = 32;
    localparam int unsigned SYNC_IDX_W = 5;
    localparam int unsigned PIN_N      = 5;

    // Sampled pin positions in the synchroniser vector
    localparam int unsigned PIN_TXCK = 0;
    localparam int unsigned PIN_RXCK = 1;
    localparam int unsigned PIN_TXFS = 2;
    localparam int unsigned PIN_RXFS = 3;
    localparam int unsigned PIN_RXD  = 4;

    // Start event selection
    localparam logic [1:0] START_CONT    = 2'h0;
    localparam logic [1:0] START_FS_RISE = 2'h1;
    localparam logic [1:0] START_FS_FALL = 2'h2;
    localparam logic [1:0] START_PERIOD  = 2'h3;

    // Reset values
    localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [PIN_N-1:0]  RST_PINS = 5'h00;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_DELAY = 4'h2,
        ST_SYNC  = 4'h4,
        ST_DATA  = 4'h8
    } ssf_state_t;
endpackage

// ==== core/ssf_top.sv ====
// Purpose: Synchronous serial transmitter and receiver with frame logic
// Assumes: Serial clocks at most a third of mclk_i; pins are asynchronous
// Notes:   All serial timing is recovered from sampled clock pin edges
`timescale 1ns/1ps
`default_nettype none

module ssf_top (
    input  wire logic                         mclk_i,
    input  wire logic                         rst_i,
    input  wire logic                         tx_clock_pin_i,
    input  wire logic                         rx_clock_pin_i,
    input  wire logic                         tx_fsync_pin_i,
    input  wire logic                         rx_fsync_pin_i,
    input  wire logic                         rx_data_pin_i,
    input  wire logic                         tx_enable_i,
    input  wire logic                         tx_clk_from_rx_i,
    input  wire logic [1:0]                   tx_start_sel_i,
    input  wire logic [ssf_pkg::DLY_W-1:0]    tx_start_delay_i,
    input  wire logic [ssf_pkg::WLEN_W-1:0]   tx_word_length_i,
    input  wire logic [ssf_pkg::WNUM_W-1:0]   tx_words_per_frame_i,
    input  wire logic [ssf_pkg::SLEN_W-1:0]   tx_sync_length_i,
    input  wire logic [ssf_pkg::PER_W-1:0]    tx_period_i,
    input  wire logic                         tx_msb_first_select_i,
    input  wire logic                         tx_sync_data_enable_i,
    input  wire logic                         tx_idle_line_level_i,
    input  wire logic [ssf_pkg::WORD_W-1:0]   tx_holding_reg_i,
    input  wire logic                         tx_holding_write_i,
    input  wire logic [ssf_pkg::SYNC_REG_W-1:0] tx_sync_holding_reg_i,
    input  wire logic                         rx_enable_i,
    input  wire logic                         rx_clk_from_tx_i,
    input  wire logic [1:0]                   rx_start_sel_i,
    input  wire logic [ssf_pkg::DLY_W-1:0]    rx_start_delay_i,
    input  wire logic [ssf_pkg::WLEN_W-1:0]   rx_word_length_i,
    input  wire logic [ssf_pkg::WNUM_W-1:0]   rx_words_per_frame_i,
    input  wire logic [ssf_pkg::SLEN_W-1:0]   rx_sync_length_i,
    input  wire logic [ssf_pkg::PER_W-1:0]    rx_period_i,
    input  wire logic                         rx_msb_first_select_i,
    output logic                              tx_data_pin_o,
    output logic                              tx_all_drained_flag_o,
    output logic                              tx_holding_free_flag_o,
    output logic [ssf_pkg::WORD_W-1:0]        rx_word_o,
    output logic                              rx_word_valid_o
);
    import ssf_pkg::*;

    // Bit position of the idx-th bit on the line within a word
    function automatic logic [WLEN_W-1:0] bit_pos(input logic [WLEN_W-1:0] len,
                                                  input logic [BCNT_W-1:0] idx,
                                                  input logic              msb_first_select);
        bit_pos = msb_first_select ? (len - idx[WLEN_W-1:0]) : idx[WLEN_W-1:0];
    endfunction

    // Pin synchronisers; stage one feeds only stage two
    logic [PIN_N-1:0] s1_q, s2_q, s3_q;
    logic             txck_rise, txck_fall, rxck_rise, rxck_fall;
    logic             tx_tick, rx_tick, txfs_rise, txfs_fall, rxfs_rise, rxfs_fall;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= RST_PINS;
            s2_q <= RST_PINS;
            s3_q <= RST_PINS;
        end else begin
            s1_q <= {rx_data_pin_i, rx_fsync_pin_i, tx_fsync_pin_i,
                     rx_clock_pin_i, tx_clock_pin_i};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        txck_rise = s2_q[PIN_TXCK] & ~s3_q[PIN_TXCK];
        txck_fall = ~s2_q[PIN_TXCK] & s3_q[PIN_TXCK];
        rxck_rise = s2_q[PIN_RXCK] & ~s3_q[PIN_RXCK];
        rxck_fall = ~s2_q[PIN_RXCK] & s3_q[PIN_RXCK];
        // Transmit changes on falling edges, receive samples on rising ones
        tx_tick   = tx_clk_from_rx_i ? rxck_fall : txck_fall;
        rx_tick   = rx_clk_from_tx_i ? txck_rise : rxck_rise;
        txfs_rise = s2_q[PIN_TXFS] & ~s3_q[PIN_TXFS];
        txfs_fall = ~s2_q[PIN_TXFS] & s3_q[PIN_TXFS];
        rxfs_rise = s2_q[PIN_RXFS] & ~s3_q[PIN_RXFS];
        rxfs_fall = ~s2_q[PIN_RXFS] & s3_q[PIN_RXFS];
    end

    // Transmit state
    ssf_state_t          tx_st_q, tx_st_d;
    logic [WORD_W-1:0]   tx_hold_q, tx_hold_d, tx_sh_q, tx_sh_d;
    logic                tx_full_q, tx_full_d, tx_pend_q, tx_pend_d;
    logic                tx_pin_q, tx_pin_d, tx_free_q, tx_free_d, tx_drn_q, tx_drn_d;
    logic [BCNT_W-1:0]   tx_bcnt_q, tx_bcnt_d;
    logic [WNUM_W-1:0]   tx_wcnt_q, tx_wcnt_d;
    logic [DLY_W-1:0]    tx_dcnt_q, tx_dcnt_d;
    logic [SLEN_W-1:0]   tx_scnt_q, tx_scnt_d;
    logic [PER_W-1:0]    tx_per_q, tx_per_d;
    logic                tx_ev, tx_enter, tx_load;

    always_comb begin
        tx_st_d   = tx_st_q;
        tx_hold_d = tx_hold_q;
        tx_sh_d   = tx_sh_q;
        tx_full_d = tx_full_q;
        tx_pend_d = tx_pend_q;
        tx_pin_d  = tx_pin_q;
        tx_bcnt_d = tx_bcnt_q;
        tx_wcnt_d = tx_wcnt_q;
        tx_dcnt_d = tx_dcnt_q;
        tx_scnt_d = tx_scnt_q;
        tx_per_d  = tx_per_q;
        tx_enter  = 1'b0;
        tx_load   = 1'b0;
        if (tx_tick) begin
            tx_per_d = (tx_per_q == tx_period_i) ? '0 : tx_per_q + 1'b1;
        end
        case (tx_start_sel_i)
            START_CONT:    tx_ev = tx_full_q;
            START_FS_RISE: tx_ev = txfs_rise;
            START_FS_FALL: tx_ev = txfs_fall;
            default:       tx_ev = tx_tick && (tx_per_q == tx_period_i);
        endcase
        if (tx_st_q == ST_IDLE && tx_ev) begin
            tx_pend_d = 1'b1;
        end
        if (tx_st_q == ST_IDLE) begin
            tx_pin_d = tx_idle_line_level_i;
        end
        if (!tx_enable_i) begin
            tx_st_d   = ST_IDLE;
            tx_pend_d = 1'b0;
            tx_pin_d  = tx_idle_line_level_i;
        end else if (tx_tick) begin
            case (tx_st_q)
                ST_IDLE: begin
                    tx_pin_d = tx_idle_line_level_i;
                    if (tx_pend_q) begin
                        tx_pend_d = 1'b0;
                        tx_wcnt_d = '0;
                        if (tx_start_delay_i != '0) begin
                            tx_st_d   = ST_DELAY;
                            tx_dcnt_d = tx_start_delay_i;
                        end else begin
                            tx_enter = 1'b1;
                        end
                    end
                end
                ST_DELAY: begin
                    tx_dcnt_d = tx_dcnt_q - 1'b1;
                    tx_enter  = (tx_dcnt_q == 8'h01);
                end
                ST_SYNC: begin
                    if (tx_scnt_q == tx_sync_length_i) begin
                        tx_st_d = ST_DATA;
                        tx_load = 1'b1;
                    end else begin
                        tx_pin_d  = tx_sync_holding_reg_i[tx_scnt_q[SYNC_IDX_W-1:0]];
                        tx_scnt_d = tx_scnt_q + 1'b1;
                    end
                end
                ST_DATA: begin
                    if (tx_bcnt_q > BCNT_W'(tx_word_length_i)) begin
                        if (tx_wcnt_q == tx_words_per_frame_i) begin
                            tx_st_d  = ST_IDLE;
                            tx_pin_d = tx_idle_line_level_i;
                        end else begin
                            tx_wcnt_d = tx_wcnt_q + 1'b1;
                            tx_load   = 1'b1;
                        end
                    end else begin
                        tx_pin_d  = tx_sh_q[bit_pos(tx_word_length_i, tx_bcnt_q,
                                                    tx_msb_first_select_i)];
                        tx_bcnt_d = tx_bcnt_q + 1'b1;
                    end
                end
                default: begin
                    tx_st_d = ST_IDLE;
                end
            endcase
        end
        if (tx_enter) begin
            // Continuous mode suppresses sync whatever the enable says
            if (tx_sync_data_enable_i && tx_start_sel_i != START_CONT
                && tx_sync_length_i != '0) begin
                tx_st_d   = ST_SYNC;
                tx_pin_d  = tx_sync_holding_reg_i[0];
                tx_scnt_d = 9'h001;
            end else begin
                tx_st_d = ST_DATA;
                tx_load = 1'b1;
            end
        end
        if (tx_load) begin
            // Underrun sends a word of idle level rather than stale data
            tx_sh_d   = tx_full_q ? tx_hold_q : {WORD_W{tx_idle_line_level_i}};
            tx_full_d = 1'b0;
            tx_pin_d  = tx_sh_d[bit_pos(tx_word_length_i, '0, tx_msb_first_select_i)];
            tx_bcnt_d = 6'h01;
        end
        if (tx_holding_write_i) begin
            // A write in the load cycle wins over the clear
            tx_hold_d = tx_holding_reg_i;
            tx_full_d = 1'b1;
        end
        tx_free_d = ~tx_full_d;
        tx_drn_d  = ~tx_full_d && (tx_st_d == ST_IDLE);
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_st_q   <= ST_IDLE;
            tx_hold_q <= RST_WORD;
            tx_sh_q   <= RST_WORD;
            tx_full_q <= 1'b0;
            tx_pend_q <= 1'b0;
            tx_pin_q  <= 1'b0;
            tx_free_q <= 1'b1;
            tx_drn_q  <= 1'b1;
            tx_bcnt_q <= '0;
            tx_wcnt_q <= '0;
            tx_dcnt_q <= '0;
            tx_scnt_q <= '0;
            tx_per_q  <= '0;
        end else begin
            tx_st_q   <= tx_st_d;
            tx_hold_q <= tx_hold_d;
            tx_sh_q   <= tx_sh_d;
            tx_full_q <= tx_full_d;
            tx_pend_q <= tx_pend_d;
            tx_pin_q  <= tx_pin_d;
            tx_free_q <= tx_free_d;
            tx_drn_q  <= tx_drn_d;
            tx_bcnt_q <= tx_bcnt_d;
            tx_wcnt_q <= tx_wcnt_d;
            tx_dcnt_q <= tx_dcnt_d;
            tx_scnt_q <= tx_scnt_d;
            tx_per_q  <= tx_per_d;
        end
    end

    // Receive state
    ssf_state_t          rx_st_q, rx_st_d;
    logic [WORD_W-1:0]   rx_sh_q, rx_sh_d, rx_out_q, rx_out_d;
    logic                rx_pend_q, rx_pend_d, rx_vld_q, rx_vld_d;
    logic [BCNT_W-1:0]   rx_bcnt_q, rx_bcnt_d;
    logic [WNUM_W-1:0]   rx_wcnt_q, rx_wcnt_d;
    logic [DLY_W-1:0]    rx_dcnt_q, rx_dcnt_d;
    logic [SLEN_W-1:0]   rx_scnt_q, rx_scnt_d;
    logic [PER_W-1:0]    rx_per_q, rx_per_d;
    logic                rx_ev, rx_enter;

    always_comb begin
        rx_st_d   = rx_st_q;
        rx_sh_d   = rx_sh_q;
        rx_out_d  = rx_out_q;
        rx_pend_d = rx_pend_q;
        rx_vld_d  = 1'b0;
        rx_bcnt_d = rx_bcnt_q;
        rx_wcnt_d = rx_wcnt_q;
        rx_dcnt_d = rx_dcnt_q;
        rx_scnt_d = rx_scnt_q;
        rx_per_d  = rx_per_q;
        rx_enter  = 1'b0;
        if (rx_tick) begin
            rx_per_d = (rx_per_q == rx_period_i) ? '0 : rx_per_q + 1'b1;
        end
        case (rx_start_sel_i)
            START_CONT:    rx_ev = 1'b1;
            START_FS_RISE: rx_ev = rxfs_rise;
            START_FS_FALL: rx_ev = rxfs_fall;
            default:       rx_ev = rx_tick && (rx_per_q == rx_period_i);
        endcase
        if (rx_st_q == ST_IDLE && rx_ev) begin
            rx_pend_d = 1'b1;
        end
        if (!rx_enable_i) begin
            rx_st_d   = ST_IDLE;
            rx_pend_d = 1'b0;
        end else if (rx_tick) begin
            case (rx_st_q)
                ST_IDLE: begin
                    if (rx_pend_q) begin
                        rx_pend_d = 1'b0;
                        rx_wcnt_d = '0;
                        if (rx_start_delay_i != '0) begin
                            rx_st_d   = ST_DELAY;
                            rx_dcnt_d = rx_start_delay_i;
                        end else begin
                            rx_enter = 1'b1;
                        end
                    end
                end
                ST_DELAY: begin
                    rx_dcnt_d = rx_dcnt_q - 1'b1;
                    rx_enter  = (rx_dcnt_q == 8'h01);
                end
                ST_SYNC: begin
                    // Sync bits are counted off, not kept
                    rx_scnt_d = rx_scnt_q + 1'b1;
                    if (rx_scnt_d == rx_sync_length_i) begin
                        rx_st_d = ST_DATA;
                    end
                end
                ST_DATA: begin
                    rx_sh_d[bit_pos(rx_word_length_i, rx_bcnt_q,
                                    rx_msb_first_select_i)] = s2_q[PIN_RXD];
                    if (rx_bcnt_q == BCNT_W'(rx_word_length_i)) begin
                        rx_out_d  = rx_sh_d;
                        rx_vld_d  = 1'b1;
                        rx_sh_d   = RST_WORD;
                        rx_bcnt_d = '0;
                        if (rx_wcnt_q == rx_words_per_frame_i) begin
                            rx_st_d = ST_IDLE;
                        end else begin
                            rx_wcnt_d = rx_wcnt_q + 1'b1;
                        end
                    end else begin
                        rx_bcnt_d = rx_bcnt_q + 1'b1;
                    end
                end
                default: begin
                    rx_st_d = ST_IDLE;
                end
            endcase
        end
        if (rx_enter) begin
            rx_sh_d   = RST_WORD;
            rx_bcnt_d = '0;
            rx_scnt_d = '0;
            rx_st_d   = (rx_sync_length_i != '0 && rx_start_sel_i != START_CONT)
                        ? ST_SYNC : ST_DATA;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_st_q   <= ST_IDLE;
            rx_sh_q   <= RST_WORD;
            rx_out_q  <= RST_WORD;
            rx_pend_q <= 1'b0;
            rx_vld_q  <= 1'b0;
            rx_bcnt_q <= '0;
            rx_wcnt_q <= '0;
            rx_dcnt_q <= '0;
            rx_scnt_q <= '0;
            rx_per_q  <= '0;
        end else begin
            rx_st_q   <= rx_st_d;
            rx_sh_q   <= rx_sh_d;
            rx_out_q  <= rx_out_d;
            rx_pend_q <= rx_pend_d;
            rx_vld_q  <= rx_vld_d;
            rx_bcnt_q <= rx_bcnt_d;
            rx_wcnt_q <= rx_wcnt_d;
            rx_dcnt_q <= rx_dcnt_d;
            rx_scnt_q <= rx_scnt_d;
            rx_per_q  <= rx_per_d;
        end
    end

    always_comb begin
        tx_data_pin_o          = tx_pin_q;
        tx_all_drained_flag_o  = tx_drn_q;
        tx_holding_free_flag_o = tx_free_q;
        rx_word_o              = rx_out_q;
        rx_word_valid_o        = rx_vld_q;
    end
endmodule

`default_nettype wire

// ==== testbench/ssf_peer.sv ====
// Purpose: Serial codec model for the frame block
// Assumes: 125 ns bit clock, standing still between frames
// Notes:   Samples the transmit pin on every rising clock edge
`timescale 1ns/1ps
`default_nettype none
module ssf_peer (
    input  wire logic        go_i,
    input  wire logic        on_rx_i,
    input  wire logic        fs_inv_i,
    input  wire logic [8:0]  ncyc_i,
    input  wire logic [63:0] seq_i,
    input  wire logic        td_i,
    output logic             txck_o,
    output logic             rxck_o,
    output logic             fs_o,
    output logic             rd_o,
    output logic [63:0]      cap_o,
    output logic             busy_o
);
    logic ck;
    logic fa;
    // Slow clock keeps the ratio limits of both pins
    assign txck_o = ck & ~on_rx_i;
    assign rxck_o = ck & on_rx_i;
    assign fs_o   = fa ^ fs_inv_i;
    initial begin
        {ck, fa, rd_o, busy_o} = 4'h0;
        cap_o = 64'h0;
        forever begin
            @(posedge go_i);
            busy_o = 1'b1;
            #100 fa = 1'b1;
            #125;
            for (int k = 0; k < int'(ncyc_i); k++) begin
                #62.5 ck = 1'b1;
                cap_o[k] = td_i;
                #62.5 ck = 1'b0;
                rd_o = seq_i[k];
            end
            #125 fa = 1'b0;
            // Released line must not keep the last bit
            rd_o = ~rd_o;
            busy_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/ssf_props.sv ====
// Purpose: Port checks on the serial frame block
// Assumes: Serial clocks far slower than mclk_i
// Notes:   Tick windows counted from raw clock pin edges
`timescale 1ns/1ps
`default_nettype none
module ssf_props (
    input wire logic                       mclk_i,
    input wire logic                       rst_i,
    input wire logic                       tx_clock_pin_i,
    input wire logic                       rx_clock_pin_i,
    input wire logic                       tx_enable_i,
    input wire logic                       tx_clk_from_rx_i,
    input wire logic                       rx_clk_from_tx_i,
    input wire logic                       tx_idle_line_level_i,
    input wire logic                       tx_holding_write_i,
    input wire logic                       tx_data_pin_o,
    input wire logic                       tx_all_drained_flag_o,
    input wire logic                       tx_holding_free_flag_o,
    input wire logic [ssf_pkg::WORD_W-1:0] rx_word_o,
    input wire logic                       rx_word_valid_o
);
    import ssf_pkg::*;
    logic       tck, rck, tck_q, rck_q;
    logic [3:0] ts_q, ts_d, rs_q, rs_d;
    // Saturating age since the last falling edge of the tx clock and rising edge of the rx clock
    always_comb begin
        tck = tx_clk_from_rx_i ? rx_clock_pin_i : tx_clock_pin_i;
        rck = rx_clk_from_tx_i ? tx_clock_pin_i : rx_clock_pin_i;
        ts_d = (tck_q && !tck) ? 4'h0 : ts_q + {3'h0, ts_q != 4'hF};
        rs_d = (!rck_q && rck) ? 4'h0 : rs_q + {3'h0, rs_q != 4'hF};
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            {tck_q, rck_q, ts_q, rs_q} <= {2'h0, 8'hFF};
        end else begin
            {tck_q, rck_q, ts_q, rs_q} <= {tck, rck, ts_d, rs_d};
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_tx_run;
        tx_enable_i ##1 tx_enable_i;
    endsequence
    property p_pin_tick;
        s_tx_run ##1 $changed(tx_data_pin_o) |-> ts_q <= 4'h8;
    endproperty
    property p_wr_free;
        tx_holding_write_i |=> !tx_holding_free_flag_o;
    endproperty
    property p_wr_drain;
        tx_holding_write_i |=> !tx_all_drained_flag_o;
    endproperty
    property p_drain_free;
        tx_all_drained_flag_o |-> tx_holding_free_flag_o;
    endproperty
    property p_free_tick;
        $rose(tx_holding_free_flag_o) |-> ts_q <= 4'h8;
    endproperty
    property p_idle;
        $fell(tx_enable_i) |=> tx_data_pin_o == $past(tx_idle_line_level_i);
    endproperty
    property p_vpulse;
        rx_word_valid_o |=> !rx_word_valid_o [*8];
    endproperty
    property p_hold;
        !rx_word_valid_o |-> rx_word_o == $past(rx_word_o);
    endproperty
    property p_vtick;
        $rose(rx_word_valid_o) |-> rs_q <= 4'h8;
    endproperty
    a_pin_tick: assert property (p_pin_tick) else $error("pin moved off a tick");
    a_wr_free: assert property (p_wr_free) else $error("free not cleared");
    a_wr_drain: assert property (p_wr_drain) else $error("drained not cleared");
    a_drain_free: assert property (p_drain_free) else $error("drained but full");
    a_free_tick: assert property (p_free_tick) else $error("free rose off a tick");
    a_idle: assert property (p_idle) else $error("pin not at idle level");
    a_vpulse: assert property (p_vpulse) else $error("valid too long");
    a_hold: assert property (p_hold) else $error("word moved without valid");
    a_vtick: assert property (p_vtick) else $error("valid off a tick");
endmodule
bind ssf_top ssf_props ssf_props_i (
    .mclk_i, .rst_i, .tx_clock_pin_i, .rx_clock_pin_i, .tx_enable_i, .tx_clk_from_rx_i,
    .rx_clk_from_tx_i, .tx_idle_line_level_i, .tx_holding_write_i, .tx_data_pin_o,
    .tx_all_drained_flag_o, .tx_holding_free_flag_o, .rx_word_o, .rx_word_valid_o
);
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the serial frame block
// Assumes: Peer model drives every serial pin
// Notes:   tx period, rx delay and rx sync inputs stay at zero; rx period is set in the continuous test
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssf_pkg::*;
    logic        mclk_i, rst_i, tx_enable_i, rx_enable_i, go, on_rx, fs_inv, busy;
    logic        tx_clk_from_rx_i, rx_clk_from_tx_i, tx_msb_first_select_i;
    logic        tx_sync_data_enable_i, tx_idle_line_level_i, tx_holding_write_i;
    logic        rx_msb_first_select_i, tx_clock_pin_i, rx_clock_pin_i;
    logic        tx_fsync_pin_i, rx_fsync_pin_i, rx_data_pin_i, tx_data_pin_o;
    logic        tx_all_drained_flag_o, tx_holding_free_flag_o, rx_word_valid_o;
    logic [1:0]  tx_start_sel_i, rx_start_sel_i;
    logic [7:0]  tx_start_delay_i, rx_start_delay_i;
    logic [4:0]  tx_word_length_i, rx_word_length_i;
    logic [3:0]  tx_words_per_frame_i, rx_words_per_frame_i;
    logic [8:0]  tx_sync_length_i, rx_sync_length_i, tx_period_i, rx_period_i, ncyc;
    logic [31:0] tx_holding_reg_i, tx_sync_holding_reg_i, rx_word_o;
    logic [63:0] seq, cap, e;
    int          errors, cmp_count, vcnt;
    ssf_top ssf_top_i (.*);
    ssf_peer ssf_peer_i (.go_i(go), .on_rx_i(on_rx), .fs_inv_i(fs_inv), .ncyc_i(ncyc),
        .seq_i(seq), .td_i(tx_data_pin_o), .txck_o(tx_clock_pin_i), .rxck_o(rx_clock_pin_i),
        .fs_o(tx_fsync_pin_i), .rd_o(rx_data_pin_i), .cap_o(cap), .busy_o(busy));
    assign rx_fsync_pin_i = tx_fsync_pin_i;
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (rx_word_valid_o === 1'b1) vcnt++;
    initial begin
        #100000;
        errors++;
        final_report();
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] w);
        tx_holding_reg_i = w;
        tx_holding_write_i = 1'b1;
        step(1);
        tx_holding_write_i = 1'b0;
        step(1);
        chk("free", tx_holding_free_flag_o, 64'h0);
        chk("drained", tx_all_drained_flag_o, 64'h0);
    endtask
    task automatic burst(input logic [8:0] n, input logic [63:0] s);
        ncyc = n;
        seq = s;
        go = 1'b1;
        step(1);
        go = 1'b0;
        for (int i = 0; i < 3000 && busy; i++) step(1);
        step(8);
    endtask
    task automatic t_two_words;
        int v;
        logic [7:0] a, b;
        {tx_start_sel_i, tx_start_delay_i, tx_word_length_i} = {2'h1, 8'h00, 5'h07};
        {tx_words_per_frame_i, tx_sync_length_i} = {4'h1, 9'h000};
        {tx_msb_first_select_i, tx_sync_data_enable_i, tx_idle_line_level_i} = 3'h5;
        {tx_clk_from_rx_i, rx_clk_from_tx_i, on_rx, fs_inv} = 4'h4;
        {rx_start_sel_i, rx_word_length_i, rx_msb_first_select_i} = {2'h1, 5'h07, 1'b0};
        {tx_enable_i, rx_enable_i} = 2'h3;
        {a, b} = 16'hB42D;
        wr({24'h0, a});
        v = vcnt;
        fork
            burst(9'h013, 64'h6E);
            begin
                // Refill as soon as the first word leaves the holding stage
                for (int i = 0; i < 2000 && tx_holding_free_flag_o !== 1'b1; i++) step(1);
                wr({24'h0, b});
            end
        join
        e = 64'h2_0001;
        for (int j = 0; j < 8; j++) begin
            e[8 - j] = a[j];
            e[16 - j] = b[j];
        end
        chk("tx bits", cap[17:0], e[17:0]);
        chk("free end", tx_holding_free_flag_o, 64'h1);
        chk("drained end", tx_all_drained_flag_o, 64'h1);
        chk("rx word", rx_word_o, 64'h6E);
        chk("rx count", vcnt - v, 64'h1);
        {tx_enable_i, rx_enable_i} = 2'h0;
        step(3);
    endtask
    task automatic t_sync_delay;
        int v;
        {tx_start_sel_i, tx_start_delay_i, tx_word_length_i} = {2'h2, 8'h03, 5'h03};
        {tx_words_per_frame_i, tx_sync_length_i} = {4'h0, 9'h004};
        {tx_msb_first_select_i, tx_sync_data_enable_i, tx_idle_line_level_i} = 3'h2;
        tx_sync_holding_reg_i = 32'h0000_0009;
        {tx_clk_from_rx_i, rx_clk_from_tx_i, on_rx, fs_inv} = 4'hB;
        {rx_start_sel_i, rx_word_length_i, rx_msb_first_select_i} = {2'h2, 5'h03, 1'b1};
        step(2);
        wr(32'h0000_0006);
        {tx_enable_i, rx_enable_i} = 2'h3;
        v = vcnt;
        burst(9'h00E, 64'hB);
        chk("tx sync frame", cap[12:0], 64'h0690);
        chk("rx word", rx_word_o, 64'hD);
        chk("rx count", vcnt - v, 64'h1);
        {tx_enable_i, rx_enable_i} = 2'h0;
        step(3);
    endtask
    task automatic t_continuous;
        logic [31:0] w;
        w = 32'hC3A5_0F96;
        {tx_start_sel_i, tx_word_length_i, tx_sync_length_i} = {2'h0, 5'h1F, 9'h008};
        {tx_start_delay_i, tx_words_per_frame_i} = 12'h000;
        {tx_msb_first_select_i, tx_sync_data_enable_i, tx_idle_line_level_i} = 3'h7;
        {tx_clk_from_rx_i, rx_clk_from_tx_i, on_rx, fs_inv} = 4'h4;
        {rx_start_sel_i, rx_word_length_i, rx_msb_first_select_i, rx_period_i} = {2'h3, 5'h03, 1'b0, 9'h014};
        wr(w);
        {tx_enable_i, rx_enable_i} = 2'h3;
        burst(9'h022, 64'h0160_0000);
        e = 64'h2_0000_0001;
        for (int j = 0; j < 32; j++) e[32 - j] = w[j];
        chk("cont bits", cap[33:0], e[33:0]);
        chk("period rx", rx_word_o, 64'hB);
        {tx_enable_i, rx_enable_i} = 2'h0;
        step(3);
        chk("idle pin", tx_data_pin_o, 64'h1);
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        {errors, cmp_count, vcnt} = {32'h0, 32'h0, 32'h0};
        {rst_i, go, on_rx, fs_inv, ncyc, seq} = '0;
        {tx_enable_i, tx_clk_from_rx_i, tx_start_sel_i, tx_start_delay_i} = '0;
        {tx_word_length_i, tx_words_per_frame_i, tx_sync_length_i, tx_period_i} = '0;
        {tx_msb_first_select_i, tx_sync_data_enable_i, tx_idle_line_level_i} = '0;
        {tx_holding_reg_i, tx_holding_write_i, tx_sync_holding_reg_i} = '0;
        {rx_enable_i, rx_clk_from_tx_i, rx_start_sel_i, rx_start_delay_i} = '0;
        {rx_word_length_i, rx_words_per_frame_i, rx_sync_length_i, rx_period_i} = '0;
        rx_msb_first_select_i = 1'b0;
        rst_i = 1'b1;
        step(6);
        rst_i = 1'b0;
        step(1);
        chk("reset state", {tx_all_drained_flag_o, tx_holding_free_flag_o,
            rx_word_valid_o, rx_word_o}, {29'h0, 3'h6, 32'h0});
        t_two_words();
        t_sync_delay();
        t_continuous();
        final_report();
    end
endmodule
`default_nettype wire
